// >>> block_level_start_done_handshake_tb.sv
// Testbench for the start/done block in back-pressure mode.
// Assumes the checker and consumer model are compiled first.
`timescale 1ns/10ps
module block_level_start_done_handshake_tb;
  logic clk_i = 0, arst_n_i = 0, go = 0, idle, rdy, fin, prc;
  logic [3:0] dly = 4'h0;
  logic [31:0] op = 32'h0, res;
  int n_fail = 0, checks = 0;
  initial forever #12.5 clk_i = ~clk_i;
  hs_ctrl #(.MODE(ctrl_pkg::backpressure_handshake_mode)) i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .go_request_i(go), .downstream_proceed_i(prc), .operand_i(op), .idle_flag_o(idle),
    .accept_ready_o(rdy), .finish_flag_o(fin), .result_word_o(res));
  consumer_model i_cons (.clk_i(clk_i), .finish_i(fin), .delay_i(dly), .proceed_o(prc));
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Holds go and the operand until ready is seen, then leaves go at keep.
  task automatic run(logic [31:0] v, logic keep, int lat);
    int n;
    n = 0;
    op = v;
    do begin
      @(negedge clk_i);
      n++;
    end while (rdy !== 1'b1 && n < 30);
    chk(n, lat);
    chk(res, v * ctrl_pkg::LATENCY + 32'h1);
    go = keep;
  endtask
  task automatic t_halt;
    go = 1;
    run(32'h0000_0007, 0, 5);
    @(negedge clk_i);
    chk(idle, 1);
    chk(fin, 0);
    $display("halt test done");
  endtask
  task automatic t_chain;
    go = 1;
    run(32'h1234_5678, 1, 5);
    chk(idle, 0);
    run(32'hFFFF_FFFF, 0, 5);
    @(negedge clk_i);
    chk(idle, 1);
    $display("chain test done");
  endtask
  task automatic t_stall;
    dly = 4'h3;
    go = 1;
    run(32'h0000_00FF, 0, 8);
    dly = 4'h0;
    @(negedge clk_i);
    chk(fin, 0);
    $display("stall test done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #(2000 * 25);
    n_fail++;
    report_and_stop;
  end
  initial begin
    repeat (6) @(negedge clk_i);
    arst_n_i = 1;
    chk({idle, fin, rdy}, 3'b100);
    repeat (3) @(negedge clk_i);
    chk(fin, 0);
    t_halt;
    t_chain;
    t_stall;
    report_and_stop;
  end
endmodule
bind hs_ctrl hs_ctrl_chk #(.WIDTH(WIDTH)) i_chk (.clk_i, .arst_n_i, .go_request_i, .downstream_proceed_i,
  .operand_i, .idle_flag_o, .accept_ready_o, .finish_flag_o, .result_word_o);

// >>> consumer_model.sv
// Consumer that accepts a finished result after delay_i cycles.
// Assumes finish_i comes from the block on the rising edge.
`timescale 1ns/10ps
module consumer_model (
  input wire logic clk_i,
  input wire logic finish_i,
  input wire logic [3:0] delay_i,
  output logic proceed_o
);
  logic [3:0] cnt = 4'h0;
  always_ff @(posedge clk_i) cnt <= finish_i ? cnt + 4'h1 : 4'h0;
  assign proceed_o = (cnt >= delay_i);
endmodule

// >>> ctrl_pkg.sv
// Shared constants for the block-level start/done handshake controller.
// Assumes a single clock domain at 40 MHz.
package ctrl_pkg;

  // Handshake mode encodings.
  typedef enum logic [1:0] {
    basic_handshake_mode = 2'b00,
    backpressure_handshake_mode = 2'b01,
    handshake_free_mode = 2'b10
  } hs_mode_t;

  // Controller state encodings.
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_busy = 2'b01,
    st_hold = 2'b10
  } ctrl_state_t;

  localparam int unsigned RESULT_WIDTH = 32;
  localparam int unsigned LATENCY = 4;
  localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 32'h0000_0000;
  localparam logic [RESULT_WIDTH-1:0] ACC_SEED = 32'h0000_0001;

endpackage

// >>> hs_ctrl.sv
// Block-level start/done handshake controller with a small worked function.
// Assumes all inputs are synchronous to clk_i and a single clock domain.
`timescale 1ns/10ps

// What this block does
// - Wait idle after reset until go_request High.
// - Drop idle_flag at once when starting.
// - Raise finish_flag when an operation completes.
// - result_word valid whenever finish_flag High.
// - accept_ready stays Low until operation started.
// - Non-pipelined: accept_ready together with finish_flag; in back-pressure mode only once downstream_proceed High.
// - go_request Low at ready: finish, halt.
// - go_request High at ready: restart immediately.
// - On halt idle_flag rises after finish_flag.
// - Back-to-back operation keeps idle_flag Low.
// - Back-pressure mode adds downstream_proceed input.
// - downstream_proceed High at finish: keep operating.
// - downstream_proceed Low: hold finish and result.
// - Handshake-free mode ignores the handshake inputs and ties the handshake outputs Low.
// - result_word carries the result only with a return value; with HAS_RESULT 0 it is tied to zero.
// - Default mode is the basic handshake.
module hs_ctrl #(
  parameter ctrl_pkg::hs_mode_t MODE = ctrl_pkg::basic_handshake_mode,
  parameter bit HAS_RESULT = 1'b1,
  parameter int unsigned WIDTH = ctrl_pkg::RESULT_WIDTH,
  parameter int unsigned LATENCY = ctrl_pkg::LATENCY
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic go_request_i,
  input wire logic downstream_proceed_i,
  input wire logic [WIDTH-1:0] operand_i,
  output logic idle_flag_o,
  output logic accept_ready_o,
  output logic finish_flag_o,
  output logic [WIDTH-1:0] result_word_o
);

  // In handshake-free mode the handshake ports are unused and read as tied:
  // the block free-runs and its handshake outputs are forced Low.
  wire logic free_mode = (MODE == ctrl_pkg::handshake_free_mode);
  wire logic chain_mode = (MODE == ctrl_pkg::backpressure_handshake_mode);
  wire logic go = free_mode ? 1'b1 : go_request_i;
  // Outside the back-pressure mode the proceed input is ignored.
  wire logic proceed = chain_mode ? downstream_proceed_i : 1'b1;

  ctrl_pkg::ctrl_state_t state;
  ctrl_pkg::ctrl_state_t next_state;
  logic [WIDTH-1:0] acc;
  logic [WIDTH-1:0] result;
  logic [WIDTH-1:0] operand;
  logic done;
  logic last;

  // The operation finishes on its last busy cycle, when the latency counter flags last.
  wire logic busy = (state == ctrl_pkg::st_busy);
  wire logic holding = (state == ctrl_pkg::st_hold);
  wire logic finish_now = busy && last;
  // A start is taken from idle, or back to back in the finish cycle, where ready stands and go is judged.
  wire logic start_idle = (state == ctrl_pkg::st_idle) && go;
  wire logic release_hold = holding && proceed;
  wire logic restart = release_hold && go;
  wire logic load = start_idle || restart;

  latency_counter #(
    .LATENCY(LATENCY),
    .CW(8)
  ) u_latency (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .load_i(load),
    .run_i(busy),
    .last_o(last)
  );

  always_comb begin
    next_state = state;
    unique case (state)
      ctrl_pkg::st_idle: begin
        if (go) begin
          next_state = ctrl_pkg::st_busy;
        end
      end
      ctrl_pkg::st_busy: begin
        if (last) begin
          next_state = ctrl_pkg::st_hold;
        end
      end
      // The finish cycle: go is looked at while ready stands, not before it.
      ctrl_pkg::st_hold: begin
        if (!proceed) begin
          next_state = ctrl_pkg::st_hold;
        end else if (go) begin
          next_state = ctrl_pkg::st_busy;
        end else begin
          next_state = ctrl_pkg::st_idle;
        end
      end
      default: begin
        next_state = ctrl_pkg::st_idle;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ctrl_pkg::st_idle;
    end else begin
      state <= next_state;
    end
  end

  // Operand is captured at start; the worked function accumulates it.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      operand <= ctrl_pkg::RESULT_RESET;
      acc <= ctrl_pkg::RESULT_RESET;
    end else if (load) begin
      operand <= operand_i;
      acc <= ctrl_pkg::ACC_SEED[WIDTH-1:0];
    end else if (busy) begin
      acc <= WIDTH'(acc + operand);
    end
  end

  // Result is registered at finish and held while finish_flag stays up.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      result <= ctrl_pkg::RESULT_RESET;
    end else if (finish_now) begin
      result <= WIDTH'(acc + operand);
    end
  end

  // Done is a registered level: high the cycle after the last compute cycle,
  // and kept high through a back-pressure hold.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      done <= 1'b0;
    end else begin
      done <= finish_now || (holding && !proceed);
    end
  end

  // Non-pipelined: ready coincides with finish, gated by proceed in back-pressure mode, and only after a start.
  assign finish_flag_o = free_mode ? 1'b0 : done;
  assign accept_ready_o = free_mode ? 1'b0 : (done && proceed);
  // Idle is Low from the start cycle on and while busy or holding.
  assign idle_flag_o = free_mode ? 1'b0 : ((state == ctrl_pkg::st_idle) && !go_request_i && !done);
  assign result_word_o = HAS_RESULT ? result : '0;

endmodule

// >>> hs_ctrl_chk.sv
// Handshake checker bound to the start/done block.
// Assumes five cycles from a taken start to finish.
`timescale 1ns/10ps
module hs_ctrl_chk #(
  parameter int unsigned WIDTH = 32
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic go_request_i,
  input wire logic downstream_proceed_i,
  input wire logic [WIDTH-1:0] operand_i,
  input wire logic idle_flag_o,
  input wire logic accept_ready_o,
  input wire logic finish_flag_o,
  input wire logic [WIDTH-1:0] result_word_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence start_s;
    go_request_i && ($past(idle_flag_o) || accept_ready_o);
  endsequence
  AST_FINISH_TIME: assert property (start_s |-> ##5 finish_flag_o) else $error("late finish");
  AST_NO_EARLY: assert property (start_s |=> !finish_flag_o [*4]) else $error("early finish");
  AST_RESULT: assert property (start_s |-> ##5 result_word_o == $past(operand_i, 5) * ctrl_pkg::LATENCY + 1)
    else $error("bad result");
  AST_IDLE_DROP: assert property (go_request_i && $past(idle_flag_o) |-> !idle_flag_o)
    else $error("idle not dropped");
  AST_READY: assert property (accept_ready_o == (finish_flag_o && downstream_proceed_i))
    else $error("bad ready");
  AST_HOLD: assert property (finish_flag_o && !downstream_proceed_i |=> finish_flag_o && $stable(result_word_o))
    else $error("stall not held");
  AST_HALT: assert property (accept_ready_o && !go_request_i |=> !finish_flag_o && (idle_flag_o || go_request_i))
    else $error("no halt");
  AST_CHAIN: assert property (accept_ready_o && go_request_i |=> !idle_flag_o [*4] ##1 finish_flag_o)
    else $error("chain broken");
endmodule

// >>> latency_counter.sv
// Cycle counter that measures the length of one operation.
// Assumes a synchronous clear and a one-cycle start pulse from the controller.
`timescale 1ns/10ps

module latency_counter #(
  parameter int unsigned LATENCY = 4,
  parameter int unsigned CW = 8
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic load_i,
  input wire logic run_i,
  output logic last_o
);

  logic [CW-1:0] count;
  wire logic [CW-1:0] top_value = CW'(LATENCY - 1);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count <= '0;
    end else if (load_i) begin
      count <= '0;
    end else if (run_i && count != top_value) begin
      count <= count + CW'(1);
    end
  end

  // Last cycle of the operation, while running.
  assign last_o = run_i && (count == top_value);

endmodule
